// [rtl/dcs_drive_ctrl.sv]
// Overview of operation
// - power-up motor code, zero means unidentified
// - encoder diagnostic position refreshed each basic cycle
// - probe one: 0 off, 210 fast input zero
// - probe two: 0 off, 211 fast input one
// - invert bits 0/1 flip probe inputs, reset zero
// - input status shows raw, uninverted levels
// - inputs 0..4 reported in bits 0..4
// - inputs 2,3 pair failsafe; 0,1 fast; 4 resistor
// - command bits 0..8 decoded active high
// - state word sent cyclically to controller
// - state bits 0..6 as defined
// - state bits 9,11..15 as defined
// - safe brake function stops close-brake driving brake
// - bits 14,15 valid only with extended brake
// - telegram code 3,5,102,105 fixes word counts
// - pulses-enabled location: word number, bit position
// - tolerance counts allowed sign-of-life errors, default 1
// - tolerance maximum disables sign-of-life monitoring
// - power-up brake type: 0 none, 1 holding
//
// dcs_drive_ctrl: control/status word and probe top
// assumes an AXI4-Lite master, telegram words synchronous to aclk
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module dcs_drive_ctrl (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire dcs_pkg::dcs_axil_req_t s_axi_req,
   output dcs_pkg::dcs_axil_rsp_t      s_axi_rsp,
   input  wire logic [4:0]             input_pins,
   input  wire logic [15:0]            motor_code_in,
   input  wire logic [15:0]            brake_type_in,
   input  wire logic                   encoder_cycle_tick,
   input  wire logic [31:0]            encoder_position_word,
   input  wire logic                   frame_valid,
   input  wire logic [15:0]            command_word_in,
   input  wire logic [15:0]            fourth_process_word,
   input  wire logic [15:0]            telegram_code_in,
   input  wire dcs_pkg::dcs_drive_fb_t drive_fb,
   output dcs_pkg::dcs_cmd_t           cmd_out,
   output logic [15:0]                 state_word_out,
   output logic                        state_word_valid,
   output logic                        brake_close_drive,
   output logic                        probe_one_level,
   output logic                        probe_two_level,
   output logic                        comm_fault
);
   import dcs_pkg::*;

   typedef struct packed {
      logic [7:0]    awaddr;
      logic          aw_got;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          w_got;
      dcs_axil_rsp_t rsp;
      logic [15:0]   probe_one_sel;
      logic [15:0]   probe_two_sel;
      logic [31:0]   invert;
      logic [15:0]   tolerance;
      logic          id_done;
      logic [15:0]   motor_code;
      logic [15:0]   brake_type;
      logic [31:0]   enc_pos;
      logic [4:0]    in_levels;
      logic [15:0]   cmd_word;
      logic          inhibit;
      logic [15:0]   state_word;
      logic          state_valid;
      logic          rx_seen;
      logic [15:0]   telegram;
      logic          brake_drive;
      dcs_cmd_t      cmd;
   } dcs_top_state_t;

   dcs_top_state_t st_reg, st_next;
   logic [15:0]    mismatch_count;
   logic           fault_now;
   logic [15:0]    sw;
   logic [7:0]     rx_words;
   logic [7:0]     tx_words;
   logic           rtso;
   logic           ready;
   logic           op_en;

   // ----------------------------------------------------------------
   // byte-lane merge for register writes
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // probe paths and sign-of-life monitor
   // ----------------------------------------------------------------
   dcs_probe_path #(.PROBE_CODE(PROBE_ONE_CODE)) u_probe_one (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .raw_level   (input_pins[0]),
      .invert      (st_reg.invert[0]),
      .select      (st_reg.probe_one_sel),
      .probe_level (probe_one_level)
   );

   dcs_probe_path #(.PROBE_CODE(PROBE_TWO_CODE)) u_probe_two (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .raw_level   (input_pins[1]),
      .invert      (st_reg.invert[1]),
      .select      (st_reg.probe_two_sel),
      .probe_level (probe_two_level)
   );

   dcs_life_monitor u_life (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .frame_valid         (frame_valid),
      .fourth_process_word (fourth_process_word),
      .tolerance           (st_reg.tolerance),
      .mismatch_count      (mismatch_count),
      .comm_fault          (fault_now)
   );

   // ----------------------------------------------------------------
   // telegram word counts (receive / send)
   // ----------------------------------------------------------------
   always_comb begin
      case (st_reg.telegram)
         TGM_STD3: begin
            rx_words = 8'd5;
            tx_words = 8'd9;
         end
         TGM_STD5: begin
            rx_words = 8'd9;
            tx_words = 8'd9;
         end
         TGM_EXT102: begin
            rx_words = 8'd6;
            tx_words = 8'd10;
         end
         TGM_EXT105: begin
            rx_words = 8'd10;
            tx_words = 8'd10;
         end
         default: begin
            rx_words = 8'd0;
            tx_words = 8'd0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state word from latched command and feedback
   // ----------------------------------------------------------------
   assign rtso  = st_reg.cmd.coast_stop_n & st_reg.cmd.quick_stop_n & ~st_reg.inhibit;
   assign ready = rtso & st_reg.cmd.ramp_stop_n;
   assign op_en = ready & st_reg.cmd.op_enable;

   always_comb begin
      sw                 = 16'h0000;
      sw[SW_RTSO]        = rtso;
      sw[SW_READY]       = ready;
      sw[SW_OP_EN]       = op_en;
      sw[SW_JOG]         = rtso & st_reg.cmd.jog_one & ~st_reg.cmd.ramp_stop_n;
      sw[SW_NO_COAST]    = st_reg.cmd.coast_stop_n;
      sw[SW_NO_QUICK]    = st_reg.cmd.quick_stop_n;
      sw[SW_INHIBIT]     = st_reg.inhibit;
      sw[SW_CTRL_REQ]    = st_reg.rx_seen & ~fault_now;
      sw[SW_PULSES]      = op_en;
      sw[SW_BRAKE_OPEN]  = drive_fb.brake_open;
      sw[SW_BRAKE_CLOSE] = ~(op_en & st_reg.cmd.brake_open_cmd);
      // valid only with extended brake
      sw[SW_BRK_PULSE]   = drive_fb.extended_brake_active_flag & drive_fb.brake_pulse_en;
      sw[SW_BRK_SETP]    = drive_fb.extended_brake_active_flag & drive_fb.brake_setpoint_en;
   end

   // ----------------------------------------------------------------
   // next state: bus slave, captures, sequence
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] rd;
      logic        rd_ok;
      logic        wr_ok;
      logic [31:0] wv;
      rd      = 32'h0000_0000;
      rd_ok   = 1'b1;
      wr_ok   = 1'b1;
      wv      = 32'h0000_0000;
      st_next = st_reg;

      // power-up reads, once after reset
      if (!st_reg.id_done) begin
         st_next.id_done    = 1'b1;
         st_next.motor_code = motor_code_in;
         st_next.brake_type = brake_type_in;
      end

      // diagnostic position once per basic cycle
      if (encoder_cycle_tick) begin
         st_next.enc_pos = encoder_position_word;
      end

      // raw input levels, never inverted
      st_next.in_levels = input_pins;

      // telegram receive
      st_next.state_valid = 1'b0;
      if (frame_valid) begin
         st_next.cmd_word    = command_word_in;
         st_next.cmd         = {<<{command_word_in[CW_JOG1:CW_ON]}};
         st_next.telegram    = telegram_code_in;
         st_next.rx_seen     = 1'b1;
         st_next.state_valid = 1'b1;
      end
      st_next.state_word = sw;

      // switch-on inhibit: set by a coast or quick stop, left only with on command low
      if (!st_reg.cmd.coast_stop_n || !st_reg.cmd.quick_stop_n) begin
         st_next.inhibit = 1'b1;
      end else if (!st_reg.cmd.ramp_stop_n) begin
         st_next.inhibit = 1'b0;
      end

      // safe brake function cuts the close-brake drive
      st_next.brake_drive = sw[SW_BRAKE_CLOSE] & ~drive_fb.safe_brake_function;

      // address and data are taken independently
      if (s_axi_req.awvalid && st_reg.rsp.awready) begin
         st_next.awaddr      = s_axi_req.awaddr;
         st_next.aw_got      = 1'b1;
         st_next.rsp.awready = 1'b0;
      end
      if (s_axi_req.wvalid && st_reg.rsp.wready) begin
         st_next.wdata      = s_axi_req.wdata;
         st_next.wstrb      = s_axi_req.wstrb;
         st_next.w_got      = 1'b1;
         st_next.rsp.wready = 1'b0;
      end

      // write once both halves are in
      if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
         case (st_reg.awaddr)
            OFF_PROBE_ONE: begin
               wv = merge({16'h0000, st_reg.probe_one_sel}, st_reg.wdata, st_reg.wstrb);
               st_next.probe_one_sel = wv[15:0];
            end
            OFF_PROBE_TWO: begin
               wv = merge({16'h0000, st_reg.probe_two_sel}, st_reg.wdata, st_reg.wstrb);
               st_next.probe_two_sel = wv[15:0];
            end
            OFF_INVERT: begin
               st_next.invert = merge(st_reg.invert, st_reg.wdata, st_reg.wstrb);
            end
            OFF_TOLERANCE: begin
               wv = merge({16'h0000, st_reg.tolerance}, st_reg.wdata, st_reg.wstrb);
               st_next.tolerance = wv[15:0];
            end
            OFF_MOTOR_CODE, OFF_ENC_POS, OFF_BRAKE_TYPE, OFF_IN_LEVELS, OFF_CMD_WORD,
            OFF_STATE_WORD, OFF_TELEGRAM, OFF_PULSE_LOC, OFF_LINK_STATUS: begin
               wr_ok = 1'b1; // read-only: write ignored
            end
            default: begin
               wr_ok = 1'b0;
            end
         endcase
         st_next.aw_got      = 1'b0;
         st_next.w_got       = 1'b0;
         st_next.rsp.bvalid  = 1'b1;
         st_next.rsp.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_reg.rsp.bvalid && s_axi_req.bready) begin
         st_next.rsp.bvalid  = 1'b0;
         st_next.rsp.awready = 1'b1;
         st_next.rsp.wready  = 1'b1;
      end

      // read: one outstanding, answer next cycle
      if (s_axi_req.arvalid && st_reg.rsp.arready) begin
         case (s_axi_req.araddr)
            OFF_MOTOR_CODE:  rd = {16'h0000, st_reg.motor_code};
            OFF_ENC_POS:     rd = st_reg.enc_pos;
            OFF_PROBE_ONE:   rd = {16'h0000, st_reg.probe_one_sel};
            OFF_PROBE_TWO:   rd = {16'h0000, st_reg.probe_two_sel};
            OFF_INVERT:      rd = st_reg.invert;
            OFF_BRAKE_TYPE:  rd = {16'h0000, st_reg.brake_type};
            OFF_IN_LEVELS:   rd = {27'h000_0000, st_reg.in_levels};
            OFF_CMD_WORD:    rd = {16'h0000, st_reg.cmd_word};
            OFF_STATE_WORD:  rd = {16'h0000, st_reg.state_word};
            OFF_TELEGRAM:    rd = {16'h0000, st_reg.telegram};
            OFF_PULSE_LOC:   rd = {16'h0000, PULSE_BIT_POS, PULSE_WORD_NUM};
            OFF_TOLERANCE:   rd = {16'h0000, st_reg.tolerance};
            OFF_LINK_STATUS: rd = {mismatch_count, tx_words[6:0], fault_now, rx_words};
            default:         rd_ok = 1'b0;
         endcase
         st_next.rsp.arready = 1'b0;
         st_next.rsp.rvalid  = 1'b1;
         st_next.rsp.rdata   = rd;
         st_next.rsp.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_reg.rsp.rvalid && s_axi_req.rready) begin
         st_next.rsp.rvalid  = 1'b0;
         st_next.rsp.arready = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg               <= '0;
         st_reg.rsp.awready   <= 1'b1;
         st_reg.rsp.wready    <= 1'b1;
         st_reg.rsp.arready   <= 1'b1;
         st_reg.probe_one_sel <= PROBE_SEL_RST;
         st_reg.probe_two_sel <= PROBE_SEL_RST;
         st_reg.invert        <= INVERT_RST;
         st_reg.tolerance     <= TOL_RST;
         st_reg.motor_code    <= MOTOR_UNKNOWN;
         st_reg.inhibit       <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign s_axi_rsp         = st_reg.rsp;
   assign cmd_out           = st_reg.cmd;
   assign state_word_out    = st_reg.state_word;
   assign state_word_valid  = st_reg.state_valid;
   assign brake_close_drive = st_reg.brake_drive;
   assign comm_fault        = fault_now;
endmodule

// [rtl/dcs_life_monitor.sv]
// dcs_life_monitor: sign-of-life check
// assumes frame_valid pulses once per telegram
`timescale 1ns/1ps
module dcs_life_monitor (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        frame_valid,
   input  wire logic [15:0] fourth_process_word,
   input  wire logic [15:0] tolerance,
   output logic [15:0]      mismatch_count,
   output logic             comm_fault
);
   import dcs_pkg::*;
   typedef struct packed {
      logic        locked;
      logic [3:0]  last_life;
      logic [15:0] count;
      logic        fault;
   } dcs_life_state_t;
   dcs_life_state_t st_reg, st_next;
   logic [3:0] life;
   logic [3:0] expect_life;

   assign life        = fourth_process_word[LIFE_LSB +: 4];
   assign expect_life = st_reg.last_life + 4'h1;

   // ----------------------------------------------------------------
   // mismatch counting and fault decision
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (frame_valid) begin
         st_next.locked    = 1'b1;
         st_next.last_life = life;
         if (!st_reg.locked || life == expect_life) begin
            st_next.count = 16'h0000;
         end else if (st_reg.count != 16'hFFFF) begin
            st_next.count = st_reg.count + 16'h0001;
         end
      end
      st_next.fault = (st_next.count > tolerance) && (tolerance != TOL_DISABLE);
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign mismatch_count = st_reg.count;
   assign comm_fault     = st_reg.fault;
endmodule

// [rtl/dcs_pkg.sv]
// dcs_pkg: constants and carrier types
// assumes one 50 MHz clock domain and an AXI4-Lite register master
package dcs_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_MOTOR_CODE  = 8'h00;
   localparam logic [7:0] OFF_ENC_POS     = 8'h04;
   localparam logic [7:0] OFF_PROBE_ONE   = 8'h08;
   localparam logic [7:0] OFF_PROBE_TWO   = 8'h0C;
   localparam logic [7:0] OFF_INVERT      = 8'h10;
   localparam logic [7:0] OFF_BRAKE_TYPE  = 8'h14;
   localparam logic [7:0] OFF_IN_LEVELS   = 8'h18;
   localparam logic [7:0] OFF_CMD_WORD    = 8'h1C;
   localparam logic [7:0] OFF_STATE_WORD  = 8'h20;
   localparam logic [7:0] OFF_TELEGRAM    = 8'h24;
   localparam logic [7:0] OFF_PULSE_LOC   = 8'h28;
   localparam logic [7:0] OFF_TOLERANCE   = 8'h2C;
   localparam logic [7:0] OFF_LINK_STATUS = 8'h30;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [15:0] PROBE_SEL_RST  = 16'h0000;
   localparam logic [15:0] PROBE_OFF      = 16'h0000;
   localparam logic [15:0] PROBE_ONE_CODE = 16'h00D2;
   localparam logic [15:0] PROBE_TWO_CODE = 16'h00D3;
   localparam logic [31:0] INVERT_RST     = 32'h0000_0000;
   localparam logic [15:0] TOL_RST        = 16'h0001;
   localparam logic [15:0] TOL_DISABLE    = 16'hFFFF;
   localparam logic [15:0] MOTOR_UNKNOWN  = 16'h0000;
   localparam logic [15:0] TGM_STD3       = 16'h0003;
   localparam logic [15:0] TGM_STD5       = 16'h0005;
   localparam logic [15:0] TGM_EXT102     = 16'h0066;
   localparam logic [15:0] TGM_EXT105     = 16'h0069;
   localparam logic [7:0]  PULSE_WORD_NUM = 8'h01;
   localparam logic [7:0]  PULSE_BIT_POS  = 8'h0B;
   localparam int          LIFE_LSB       = 12;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
   // ----------------------------------------------------------------
   // command and state bit positions
   // ----------------------------------------------------------------
   localparam int CW_ON = 0, CW_COAST = 1, CW_QUICK = 2, CW_OPEN = 3, CW_RAMP_EN = 4;
   localparam int CW_RAMP_GO = 5, CW_SPD_EN = 6, CW_BRAKE_OPEN = 7, CW_JOG1 = 8;
   localparam int SW_RTSO = 0, SW_READY = 1, SW_OP_EN = 2, SW_JOG = 3, SW_NO_COAST = 4;
   localparam int SW_NO_QUICK = 5, SW_INHIBIT = 6, SW_CTRL_REQ = 9, SW_PULSES = 11;
   localparam int SW_BRAKE_OPEN = 12, SW_BRAKE_CLOSE = 13, SW_BRK_PULSE = 14;
   localparam int SW_BRK_SETP = 15;
   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } dcs_axil_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dcs_axil_rsp_t;
   typedef struct packed {
      logic brake_open;
      logic safe_brake_function;
      logic extended_brake_active_flag;
      logic brake_pulse_en;
      logic brake_setpoint_en;
   } dcs_drive_fb_t;
   typedef struct packed {
      logic ramp_stop_n;
      logic coast_stop_n;
      logic quick_stop_n;
      logic op_enable;
      logic ramp_enable;
      logic ramp_continue;
      logic speed_enable;
      logic brake_open_cmd;
      logic jog_one;
   } dcs_cmd_t;
endpackage

// [rtl/dcs_probe_path.sv]
// dcs_probe_path: one probe path, inversion and select gate
// assumes raw input synchronous to aclk
`timescale 1ns/1ps
module dcs_probe_path #(
   parameter logic [15:0] PROBE_CODE = 16'h0000
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        raw_level,
   input  wire logic        invert,
   input  wire logic [15:0] select,
   output logic             probe_level
);
   import dcs_pkg::*;
   typedef struct packed {
      logic level;
   } dcs_probe_state_t;
   dcs_probe_state_t st_reg, st_next;

   // ----------------------------------------------------------------
   // probe level: select gate, optional invert
   // ----------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.level = (select == PROBE_CODE) & (raw_level ^ invert);
      if (select == PROBE_OFF) begin
         st_next.level = 1'b0;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign probe_level = st_reg.level;
endmodule

// [verification/dcs_ctrl_model.sv]
// dcs_ctrl_model: controller side, one telegram per go pulse
// assumes inputs change just after a rising edge
`timescale 1ns/1ps
module dcs_ctrl_model (
   input wire logic        aclk,
   input wire logic        go,
   input wire logic        bad,
   input wire logic [15:0] cmd,
   input wire logic [15:0] tgm,
   output logic            frame_valid,
   output logic [15:0]     command_word_in,
   output logic [15:0]     fourth_process_word,
   output logic [15:0]     telegram_code_in
);
   logic [3:0] life = 4'h0;
   initial {frame_valid, command_word_in, fourth_process_word, telegram_code_in} = '0;
   // idle lines show inverse; bad skips count
   always @(posedge aclk) begin
      frame_valid <= go;
      command_word_in <= go ? cmd : ~command_word_in;
      telegram_code_in <= go ? tgm : ~telegram_code_in;
      fourth_process_word <= go ? {(bad ? life + 4'h8 : life + 4'h1), 12'h000}
                                : ~fourth_process_word;
      if (go && !bad) life <= life + 4'h1;
   end
endmodule

// [verification/dcs_drive_checker.sv]
// dcs_drive_checker: port checks on dcs_drive_ctrl
// assumes one clock and a sync active-low reset
`timescale 1ns/1ps
module dcs_drive_checker (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire dcs_pkg::dcs_axil_req_t s_axi_req,
   input wire dcs_pkg::dcs_axil_rsp_t s_axi_rsp,
   input wire logic                   frame_valid,
   input wire logic [15:0]            command_word_in,
   input wire dcs_pkg::dcs_drive_fb_t drive_fb,
   input wire dcs_pkg::dcs_cmd_t      cmd_out,
   input wire logic [15:0]            state_word_out,
   input wire logic                   state_word_valid,
   input wire logic                   brake_close_drive
);
   import dcs_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------
   // checks
   // ------
   sw_sent_a: assert property (frame_valid |=> state_word_valid)
      else $error("no state word");
   sw_single_a: assert property (!frame_valid |=> !state_word_valid)
      else $error("stray state word");
   cmd_decode_a: assert property (frame_valid |=>
      cmd_out.jog_one == $past(command_word_in[8]) && cmd_out.coast_stop_n == $past(command_word_in[1]))
      else $error("command bits wrong");
   brake_sbc_a: assert property (drive_fb.safe_brake_function |=> !brake_close_drive)
      else $error("brake driven under safe brake");
   pulses_a: assert property (state_word_out[SW_PULSES] == state_word_out[SW_OP_EN])
      else $error("pulses bit wrong");
   coast_a: assert property (state_word_out[SW_NO_COAST] == $past(cmd_out.coast_stop_n))
      else $error("coast bit wrong");
   inhibit_set_a: assert property (!cmd_out.quick_stop_n |-> ##[1:3] state_word_out[SW_INHIBIT])
      else $error("inhibit not set");
   read_ans_a: assert property (s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid)
      else $error("read not answered");
   cover property (frame_valid ##1 state_word_valid);
   cover property (drive_fb.safe_brake_function);
   cover property (s_axi_rsp.bvalid && s_axi_rsp.bresp == RESP_SLVERR);
endmodule
bind dcs_drive_ctrl dcs_drive_checker u_chk (.aclk, .aresetn, .s_axi_req, .s_axi_rsp,
   .frame_valid, .command_word_in, .drive_fb, .cmd_out, .state_word_out,
   .state_word_valid, .brake_close_drive);

// [verification/tb_top.sv]
// tb_top: bench for dcs_drive_ctrl
// assumes package, checker and model compiled first
`timescale 1ns/1ps
module tb_top;
   import dcs_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, bad = 1'b0, tick = 1'b0;
   logic [4:0] pins;
   logic [15:0] mc, bt = 16'h0001, cmd = '0, tgm = '0, cw, fpw, tc, sw;
   logic [31:0] pos = '0, ex [logic [7:0]];
   logic [15:0] tcodes [4] = '{TGM_STD3, TGM_STD5, TGM_EXT102, TGM_EXT105};
   dcs_axil_req_t rq = '0;
   dcs_axil_rsp_t rsp;
   dcs_drive_fb_t fb = '0;
   dcs_cmd_t co;
   logic fv, svv, bcd, p1, p2, flt;
   int err_total = 0, checks = 0, cyc = 0, seed = 50694, n;
   always #10 aclk = ~aclk;
   dcs_drive_ctrl u_dut (.aclk, .aresetn, .s_axi_req(rq), .s_axi_rsp(rsp), .input_pins(pins),
      .motor_code_in(mc), .brake_type_in(bt), .encoder_cycle_tick(tick),
      .encoder_position_word(pos), .frame_valid(fv), .command_word_in(cw),
      .fourth_process_word(fpw), .telegram_code_in(tc), .drive_fb(fb), .cmd_out(co),
      .state_word_out(sw), .state_word_valid(svv), .brake_close_drive(bcd),
      .probe_one_level(p1), .probe_two_level(p2), .comm_fault(flt));
   dcs_ctrl_model u_ctl (.aclk, .go, .bad, .cmd, .tgm, .frame_valid(fv),
      .command_word_in(cw), .fourth_process_word(fpw), .telegram_code_in(tc));
   // compare and count
   task automatic chk(input logic [31:0] e, g, input string s);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   // write one word, update the model
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      rq <= '{awaddr: a, awvalid: 1, wdata: d, wstrb: 4'hF, wvalid: 1, bready: 1, default: 0};
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (rq.awvalid && rsp.awready) rq.awvalid <= 1'b0;
         if (rq.wvalid && rsp.wready) rq.wvalid <= 1'b0;
      end while (!(rsp.bvalid && rq.bready) && n < 50);
      chk(ex.exists(a) ? RESP_OKAY : RESP_SLVERR, rsp.bresp, "bresp");
      rq.bready <= 1'b0;
      if (a == OFF_INVERT) ex[a] = d;
      else if (a inside {OFF_PROBE_ONE, OFF_PROBE_TWO, OFF_TOLERANCE}) ex[a] = d[15:0];
   endtask
   // read one word, compare with model
   task automatic rd_chk(input logic [7:0] a);
      @(posedge aclk);
      rq <= '{araddr: a, arvalid: 1, rready: 1, default: 0};
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (rq.arvalid && rsp.arready) rq.arvalid <= 1'b0;
      end while (!(rsp.rvalid && rq.rready) && n < 50);
      chk(ex.exists(a) ? ex[a] : 0, rsp.rdata, "rdata");
      chk(ex.exists(a) ? RESP_OKAY : RESP_SLVERR, rsp.rresp, "rresp");
      rq.rready <= 1'b0;
   endtask
   // one telegram
   task automatic frame(input logic b, input logic [15:0] t);
      @(posedge aclk);
      go <= 1'b1;
      bad <= b;
      tgm <= t;
      cmd <= $random(seed);
      fb <= $random(seed);
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic conclude;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
   end
   // ------
   // main sequence
   // ------
   initial begin
      mc = $random(seed);
      pins = $random(seed);
      ex = '{OFF_MOTOR_CODE: mc, OFF_ENC_POS: 0, OFF_PROBE_ONE: PROBE_SEL_RST,
             OFF_PROBE_TWO: PROBE_SEL_RST, OFF_INVERT: INVERT_RST, OFF_BRAKE_TYPE: bt,
             OFF_IN_LEVELS: pins, OFF_TELEGRAM: 0, OFF_TOLERANCE: TOL_RST,
             OFF_PULSE_LOC: {PULSE_BIT_POS, PULSE_WORD_NUM}};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ex[a]) rd_chk(a);
      rd_chk(8'h40);
      wr(8'h40, 32'h0000_0001);
      wr(OFF_MOTOR_CODE, 32'hFFFF_FFFF);
      rd_chk(OFF_MOTOR_CODE);
      @(posedge aclk);
      pos <= $random(seed);
      tick <= 1'b1;
      @(posedge aclk);
      ex[OFF_ENC_POS] = pos;
      pos <= ~pos;
      tick <= 1'b0;
      rd_chk(OFF_ENC_POS);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_PROBE_ONE, i[0] ? 210 : 0);
         wr(OFF_PROBE_TWO, i[1] ? 211 : 5);
         wr(OFF_INVERT, $random(seed));
         repeat (4) begin
            @(posedge aclk);
            pins <= $random(seed);
            repeat (2) @(posedge aclk);
            chk(ex[OFF_PROBE_ONE] == 210 && (pins[0] ^ ex[OFF_INVERT][0]), p1, "p1");
            chk(ex[OFF_PROBE_TWO] == 211 && (pins[1] ^ ex[OFF_INVERT][1]), p2, "p2");
            ex[OFF_IN_LEVELS] = pins;
            rd_chk(OFF_IN_LEVELS);
         end
      end
      foreach (tcodes[k]) begin
         frame(1'b0, tcodes[k]);
         ex[OFF_TELEGRAM] = tcodes[k];
         rd_chk(OFF_TELEGRAM);
      end
      frame(1'b1, TGM_EXT105);
      chk(0, flt, "fault");
      frame(1'b1, TGM_EXT105);
      chk(1, flt, "fault");
      repeat (3) frame(1'b0, TGM_EXT105);
      chk(0, flt, "fault");
      wr(OFF_TOLERANCE, 32'h0000_0000);
      frame(1'b1, TGM_EXT105);
      chk(1, flt, "fault");
      wr(OFF_TOLERANCE, 32'h0000_FFFF);
      frame(1'b1, TGM_EXT105);
      chk(0, flt, "fault");
      rd_chk(OFF_TOLERANCE);
      conclude();
   end
endmodule
